// [verilog/srst_top.sv]
// Reset controller: source merging, sticky cause flags, wake flags and the
// protected software reset trigger, all behind an AXI4-Lite slave.
// Assumes CLK at 125 MHz, RST as the power-on reset, and a master that keeps
// AXI4-Lite rules.
//
// How it works
// RULE_01: Every source feeds one master system reset that is high while any source asserts.
// RULE_02: Six sources are merged: power-on, clear pin, software, watchdog, brown-out, mismatch.
// RULE_03: Bit 3 of the cause status is set on waking from Sleep and left clear otherwise.
// RULE_04: Bit 2 of the cause status is set on waking from Idle.
// RULE_05: Waking from Sleep sets the idle flag as well as the sleep flag.
// RULE_06: Bit 1 of the cause status is set whenever a brown-out reset occurs.
// RULE_07: Bit 0 of the cause status is set whenever a power-on reset occurs.
// RULE_08: The cause flags hold until software clears them, so a repeat shows only after that.
// RULE_09: Writing one to trigger bit 0 arms a software reset, zero does nothing, hardware clears it.
// RULE_10: Software unlocks first, and a trigger write while locked does not arm.
// RULE_11: A read of the trigger register while armed asserts the master system reset.
// RULE_12: Bits 31 to 1 of the trigger register read as zero.
// RULE_13: The mode bit picks Sleep when set and Idle when clear on a wait instruction.
// RULE_14: The software reset goes through the common merge path and leaves the arm bit clear.
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`include "srst_defines.svh"
module srst_top (
    // Clock and power-on reset.
    input wire logic CLK,
    input wire logic RST,
    // AXI4-Lite write address and data.
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    // AXI4-Lite write response.
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read.
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Reset source inputs.
    input wire logic EXT_CLEAR_PIN_N,
    input wire logic BROWNOUT_DETECT,
    input wire logic WATCHDOG_TIMEOUT,
    input wire logic CONFIG_MISMATCH,
    // Processor power events.
    input wire logic WAIT_EXECUTED,
    input wire logic WAKE_EVENT,
    // Outputs.
    output logic MASTER_SYSTEM_RESET,
    output logic LOW_POWER_SLEEP,
    output logic LOW_POWER_IDLE
);
    import srst_pkg::*;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Matches a bus address against a register offset on its word.
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr[7:2] == off[7:2]);
    endfunction

    // True when the address lands on any mapped register.
    function automatic logic mapped(input logic [7:0] addr);
        mapped = hit(addr, `SRST_OFF_CAUSE) || hit(addr, `SRST_OFF_TRIG) ||
                 hit(addr, `SRST_OFF_MODE) || hit(addr, `SRST_OFF_UNLOCK);
    endfunction

    srst_if rif ();

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.
    logic clr_meta_r;
    logic clr_sync_r;
    logic brn_meta_r;
    logic brn_sync_r;

    // Two flip-flops for each pin; the clear pin idles high, the detector low.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            clr_meta_r <= 1'b1;
            clr_sync_r <= 1'b1;
            brn_meta_r <= 1'b0;
            brn_sync_r <= 1'b0;
        end else begin
            clr_meta_r <= EXT_CLEAR_PIN_N;
            clr_sync_r <= clr_meta_r;
            brn_meta_r <= BROWNOUT_DETECT;
            brn_sync_r <= brn_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel.

    logic aw_held_r;
    logic [7:0] aw_addr_r;
    logic w_held_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic wr_fire;

    // A write is done once address and data are both held and no response waits.
    assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
    assign S_AXI_AWREADY = !aw_held_r;
    assign S_AXI_WREADY = !w_held_r;

    // Address holding stage.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
        end else if (S_AXI_AWVALID && !aw_held_r) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= S_AXI_AWADDR;
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end
    end

    // Data holding stage.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            w_held_r <= 1'b0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
        end else if (S_AXI_WVALID && !w_held_r) begin
            w_held_r <= 1'b1;
            w_data_r <= S_AXI_WDATA;
            w_strb_r <= S_AXI_WSTRB;
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end
    end

    // Write response, an error for an unmapped address.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r <= mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            bvalid_r <= 1'b0;
        end
    end

    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP = bresp_r;

    // Write strobes per register; cause and mode need the low byte lane, unlock needs all four lanes.
    logic wr_cause;
    logic wr_trig;
    logic wr_mode;
    logic wr_unlock;

    assign wr_cause = wr_fire && hit(aw_addr_r, `SRST_OFF_CAUSE) && w_strb_r[0];
    assign wr_trig = wr_fire && hit(aw_addr_r, `SRST_OFF_TRIG);
    assign wr_mode = wr_fire && hit(aw_addr_r, `SRST_OFF_MODE) && w_strb_r[0];
    assign wr_unlock = wr_fire && hit(aw_addr_r, `SRST_OFF_UNLOCK) && (&w_strb_r);

    ////////////////////////////////////////////////////////////////////////////
    // Unlock sequence and software trigger.
    srst_lock_t lock_r;
    logic arm_r;
    logic sw_req_r;
    logic rd_trig;

    // Two keys in a row open the lock; anything else, or a trigger write, closes it.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            lock_r <= SRST_LK_LOCKED;
        end else if (wr_unlock) begin
            if (w_data_r == `SRST_KEY1) begin
                lock_r <= SRST_LK_KEY1;
            end else if (lock_r == SRST_LK_KEY1 && w_data_r == `SRST_KEY2) begin
                lock_r <= SRST_LK_OPEN;
            end else begin
                lock_r <= SRST_LK_LOCKED;
            end
        end else if (wr_trig) begin
            lock_r <= SRST_LK_LOCKED;
        end
    end

    // Arm bit: set only by an unlocked write of one, cleared once reset is issued.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            arm_r <= 1'b0;
        end else if (rif.sys_rst && !sw_req_r) begin
            arm_r <= 1'b0; // [RULE_14]
        end else if (wr_trig && w_strb_r[0] && w_data_r[`SRST_BIT_ARM] &&
                     lock_r == SRST_LK_OPEN) begin
            arm_r <= 1'b1; // [RULE_09] [RULE_10]
        end
    end

    // A read of the trigger register while armed requests the reset.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sw_req_r <= 1'b0;
        end else begin
            sw_req_r <= rd_trig && arm_r; // [RULE_11]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Low-power state and mode select.

    logic deep_low_power_select_r;
    srst_lp_t lp_r;
    srst_lp_t lp_nxt;
    logic wake_fire;

    // Mode register, low byte lane.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            deep_low_power_select_r <= `SRST_MODE_RST;
        end else if (wr_mode) begin
            deep_low_power_select_r <= w_data_r[`SRST_BIT_DEEP];
        end
    end

    // Wait enters Sleep or Idle by the mode bit; wake or reset returns to run.
    always_comb begin
        lp_nxt = lp_r;
        unique case (lp_r)
            SRST_LP_RUN: begin
                if (WAIT_EXECUTED) begin
                    lp_nxt = deep_low_power_select_r ? SRST_LP_SLEEP : SRST_LP_IDLE; // [RULE_13]
                end
            end
            SRST_LP_IDLE, SRST_LP_SLEEP: begin
                if (WAKE_EVENT) begin
                    lp_nxt = SRST_LP_RUN;
                end
            end
            default: begin
                lp_nxt = SRST_LP_RUN;
            end
        endcase
        if (rif.sys_rst) begin
            lp_nxt = SRST_LP_RUN;
        end
    end

    // Low-power state register.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            lp_r <= SRST_LP_RUN;
        end else begin
            lp_r <= lp_nxt;
        end
    end

    assign wake_fire = WAKE_EVENT && lp_r != SRST_LP_RUN;
    assign LOW_POWER_SLEEP = (lp_r == SRST_LP_SLEEP);
    assign LOW_POWER_IDLE = (lp_r == SRST_LP_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // Sticky cause flags; a write of zero clears a bit, a set in the same cycle wins.

    logic [3:0] cause_r;
    logic [3:0] cause_set;
    logic [3:0] cause_clr;
    logic por_pulse_r;

    // One-cycle power-on source after the release of RST.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            por_pulse_r <= 1'b1;
        end else begin
            por_pulse_r <= 1'b0;
        end
    end

    // Events that set flags.
    always_comb begin
        cause_set = 4'h0;
        cause_set[`SRST_BIT_POR] = por_pulse_r; // [RULE_07]
        cause_set[`SRST_BIT_BRN] = brn_sync_r; // [RULE_06]
        cause_set[`SRST_BIT_IDLE] = wake_fire; // [RULE_04] [RULE_05]
        cause_set[`SRST_BIT_SLEEP] = wake_fire && lp_r == SRST_LP_SLEEP; // [RULE_03]
        cause_clr = wr_cause ? ~w_data_r[3:0] : 4'h0;
    end

    // Flag register, held until software clears it.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cause_r <= `SRST_CAUSE_RST; // [RULE_07]
        end else begin
            cause_r <= cause_set | (cause_r & ~cause_clr); // [RULE_08]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel.

    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic rd_fire;
    logic [31:0] rd_word;

    assign rd_fire = S_AXI_ARVALID && !rvalid_r;
    assign rd_trig = rd_fire && hit(S_AXI_ARADDR, `SRST_OFF_TRIG);
    assign S_AXI_ARREADY = !rvalid_r;

    // Read multiplexer; the trigger register always reads zero.
    always_comb begin
        rd_word = 32'h00000000; // [RULE_12]
        if (hit(S_AXI_ARADDR, `SRST_OFF_CAUSE)) begin
            rd_word[3:0] = cause_r;
        end else if (hit(S_AXI_ARADDR, `SRST_OFF_MODE)) begin
            rd_word[`SRST_BIT_DEEP] = deep_low_power_select_r;
            rd_word[1:0] = lp_r;
        end else if (hit(S_AXI_ARADDR, `SRST_OFF_UNLOCK)) begin
            rd_word[1:0] = lock_r;
        end
    end

    // Read data and response register.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_word;
            rresp_r <= mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_RREADY) begin
            rvalid_r <= 1'b0;
        end
    end

    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RDATA = rdata_r;
    assign S_AXI_RRESP = rresp_r;

    ////////////////////////////////////////////////////////////////////////////
    // Source vector and merger.
    // Brown-out and clear pin are synchronised; watchdog and mismatch are on CLK.
    always_comb begin
        rif.src[0] = por_pulse_r; // [RULE_02]
        rif.src[1] = !clr_sync_r;
        rif.src[2] = sw_req_r; // [RULE_14]
        rif.src[3] = WATCHDOG_TIMEOUT;
        rif.src[4] = brn_sync_r;
        rif.src[5] = CONFIG_MISMATCH;
    end

    srst_merge u_merge (
        .clk(CLK),
        .rst(RST),
        .rif(rif.merge)
    );

    assign MASTER_SYSTEM_RESET = rif.sys_rst; // [RULE_01]
endmodule

// [pkg/srst_defines.svh]
// Offsets, field positions, reset values and timing counts of the reset controller.
// Assumes a 125 MHz system clock and a 32-bit AXI4-Lite register bus.
`ifndef SRST_DEFINES_SVH
`define SRST_DEFINES_SVH

// Register byte offsets.
`define SRST_OFF_CAUSE 8'h00
`define SRST_OFF_TRIG 8'h04
`define SRST_OFF_MODE 8'h08
`define SRST_OFF_UNLOCK 8'h0C

// Cause status field positions.
`define SRST_BIT_POR 0
`define SRST_BIT_BRN 1
`define SRST_BIT_IDLE 2
`define SRST_BIT_SLEEP 3
// Trigger and mode field positions.
`define SRST_BIT_ARM 0
`define SRST_BIT_DEEP 4

// Reset values: the power-on flag is set by the reset that starts the block.
`define SRST_CAUSE_RST 4'h1
`define SRST_MODE_RST 1'b0

// Unlock keys, values are arbitrary.
`define SRST_KEY1 32'h0000C0DE
`define SRST_KEY2 32'h0000DEC0

// Least hold time of the master reset and its cycle count at 125 MHz.
`define SRST_HOLD_NS 64
`define SRST_CLK_MHZ 125
`define SRST_HOLD_CYC ((`SRST_HOLD_NS * `SRST_CLK_MHZ + 999) / 1000)

`endif

// [pkg/srst_pkg.sv]
// Types shared by the reset controller modules.
// Assumes nothing beyond a SystemVerilog compiler.
package srst_pkg;
    // Reset source vector: por, clear pin, software, watchdog, brown-out, mismatch.
    typedef logic [5:0] srst_src_t;
    // Low-power state of the processor.
    typedef enum logic [1:0] {
        SRST_LP_RUN = 2'b00,
        SRST_LP_IDLE = 2'b01,
        SRST_LP_SLEEP = 2'b10
    } srst_lp_t;
    // Unlock sequence state.
    typedef enum logic [1:0] {
        SRST_LK_LOCKED = 2'b00,
        SRST_LK_KEY1 = 2'b01,
        SRST_LK_OPEN = 2'b10
    } srst_lock_t;
endpackage

// [pkg/srst_if.sv]
// Carrier between the register side and the reset merger.
// Assumes both ends sit on the same system clock.
interface srst_if;
    import srst_pkg::*;
    srst_src_t src;
    logic sys_rst;
    modport ctrl (output src, input sys_rst);
    modport merge (input src, output sys_rst);
endinterface

// [verilog/srst_merge.sv]
// Merges all reset sources into one stretched master system reset.
// Assumes sources are already in the system clock domain.
`include "srst_defines.svh"
module srst_merge (
    // Clock and power-on reset.
    input wire logic clk,
    input wire logic rst,
    // Sources in, master reset out.
    srst_if.merge rif
);
    import srst_pkg::*;

    localparam logic [3:0] HOLD = 4'(`SRST_HOLD_CYC);

    logic [3:0] hold_r;
    logic sys_rst_r;

    ////////////////////////////////////////////////////////////////////////////
    // Any source reloads the hold count, so a short pulse still gives a full reset.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_r <= HOLD;
        end else if (|rif.src) begin // [RULE_01]
            hold_r <= HOLD;
        end else if (hold_r != 4'h0) begin
            hold_r <= hold_r - 4'h1;
        end
    end

    // Registered master reset, high during power-on reset as well.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sys_rst_r <= 1'b1;
        end else begin
            sys_rst_r <= (|rif.src) || (hold_r > 4'h1); // [RULE_01] [RULE_14]
        end
    end

    assign rif.sys_rst = sys_rst_r;
endmodule

// [sim/srst_top_assertions.sv]
// Checker for the reset controller top level, bound to every instance.
// Assumes the bus master holds RREADY high while it waits for read data.
`include "srst_defines.svh"
module srst_top_assertions (
    // Clock and power-on reset.
    input wire logic CLK,
    input wire logic RST,
    // Read channel.
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    input wire logic S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic S_AXI_RVALID,
    // Sources and power events.
    input wire logic EXT_CLEAR_PIN_N,
    input wire logic BROWNOUT_DETECT,
    input wire logic WATCHDOG_TIMEOUT,
    input wire logic CONFIG_MISMATCH,
    input wire logic WAIT_EXECUTED,
    input wire logic WAKE_EVENT,
    // Outputs.
    input wire logic MASTER_SYSTEM_RESET,
    input wire logic LOW_POWER_SLEEP,
    input wire logic LOW_POWER_IDLE
);
    timeunit 1ns;
    timeprecision 100ps;
    logic trig_rd_r;
    logic [2:0] age_r;
    logic any_cause;
    ////////////////////////////////////////////////////////////////////////
    // Any input that may start a master reset, every accepted read included.
    assign any_cause = !EXT_CLEAR_PIN_N || BROWNOUT_DETECT || WATCHDOG_TIMEOUT ||
        CONFIG_MISMATCH || (S_AXI_ARVALID && S_AXI_ARREADY);
    // Remembers whether the read in flight targets the trigger register.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            trig_rd_r <= 1'b0;
        end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            trig_rd_r <= (S_AXI_ARADDR == `SRST_OFF_TRIG);
        end
    end
    // Cycles since the last cause, saturating so that a stray reset shows.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            age_r <= 3'h0;
        end else if (any_cause) begin
            age_r <= 3'h0;
        end else if (age_r != 3'h7) begin
            age_r <= age_r + 3'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    src_fast_a: assert property ((WATCHDOG_TIMEOUT || CONFIG_MISMATCH) |=>
        MASTER_SYSTEM_RESET) else $error("direct source gave no reset");
    src_sync_a: assert property ((!EXT_CLEAR_PIN_N || BROWNOUT_DETECT) |->
        ##[1:4] MASTER_SYSTEM_RESET) else $error("synced source gave no reset");
    rst_hold_a: assert property ($rose(MASTER_SYSTEM_RESET) |->
        MASTER_SYSTEM_RESET[*8]) else $error("master reset too short");
    rst_cause_a: assert property ($rose(MASTER_SYSTEM_RESET) |->
        age_r < 3'h6) else $error("master reset without a cause");
    trig_zero_a: assert property (S_AXI_RVALID && trig_rd_r |->
        S_AXI_RDATA[31:1] == 31'h0) else $error("trigger upper bits not zero");
    rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
        S_AXI_RVALID) else $error("read not answered");
    ar_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("address taken while data pending");
    wait_enter_a: assert property (WAIT_EXECUTED && !MASTER_SYSTEM_RESET &&
        !LOW_POWER_SLEEP && !LOW_POWER_IDLE |=> LOW_POWER_SLEEP != LOW_POWER_IDLE)
        else $error("wait gave no low-power state");
    wake_exit_a: assert property (WAKE_EVENT && (LOW_POWER_SLEEP || LOW_POWER_IDLE)
        |=> !LOW_POWER_SLEEP && !LOW_POWER_IDLE) else $error("wake did not return to run");
    lp_force_a: assert property (MASTER_SYSTEM_RESET |=>
        !LOW_POWER_SLEEP && !LOW_POWER_IDLE) else $error("low power kept in reset");
endmodule
bind srst_top srst_top_assertions chk (.CLK, .RST, .S_AXI_ARADDR, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID, .EXT_CLEAR_PIN_N, .BROWNOUT_DETECT,
    .WATCHDOG_TIMEOUT, .CONFIG_MISMATCH, .WAIT_EXECUTED, .WAKE_EVENT,
    .MASTER_SYSTEM_RESET, .LOW_POWER_SLEEP, .LOW_POWER_IDLE);

// [sim/tb_top.sv]
// Self-checking bench for the reset controller: bus tasks and directed tests.
// Assumes the package, interface, defines and design are compiled first.
`include "srst_defines.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic CLK, RST, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
    logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic S_AXI_RREADY, EXT_CLEAR_PIN_N, BROWNOUT_DETECT, WATCHDOG_TIMEOUT;
    logic CONFIG_MISMATCH, WAIT_EXECUTED, WAKE_EVENT, MASTER_SYSTEM_RESET;
    logic LOW_POWER_SLEEP, LOW_POWER_IDLE, seen;
    logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
    logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd;
    logic [3:0] S_AXI_WSTRB;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rs;
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    srst_top dut (.CLK, .RST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
        .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
        .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
        .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY, .EXT_CLEAR_PIN_N, .BROWNOUT_DETECT,
        .WATCHDOG_TIMEOUT, .CONFIG_MISMATCH, .WAIT_EXECUTED, .WAKE_EVENT,
        .MASTER_SYSTEM_RESET, .LOW_POWER_SLEEP, .LOW_POWER_IDLE);
    ////////////////////////////////////////////////////////////////////////
    // Free-running 125 MHz clock.
    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end
    // Cuts a hung run short.
    always @(posedge CLK) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_errors = n_errors + 1;
            $display("MISMATCH %0t run timed out", $time);
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then stops.
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Compares one value and counts it.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // One write; valids drop at the edge each is taken, then the response.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic fa, fw, pa, pw;
        pa = 1'b1;
        pw = 1'b1;
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        do begin
            @(negedge CLK);
            fa = pa && S_AXI_AWREADY;
            fw = pw && S_AXI_WREADY;
            @(posedge CLK);
            if (fa) S_AXI_AWVALID <= 1'b0;
            if (fw) S_AXI_WVALID <= 1'b0;
            pa = pa && !fa;
            pw = pw && !fw;
        end while (pa || pw);
        do begin
            @(negedge CLK);
            fa = S_AXI_BVALID;
            rs = S_AXI_BRESP;
            @(posedge CLK);
        end while (!fa);
    endtask
    // One read, compared with the expected word.
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic f;
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        do begin
            @(negedge CLK);
            f = S_AXI_ARREADY;
            @(posedge CLK);
        end while (!f);
        S_AXI_ARVALID <= 1'b0;
        do begin
            @(negedge CLK);
            f = S_AXI_RVALID;
            rd = S_AXI_RDATA;
            rs = S_AXI_RRESP;
            @(posedge CLK);
        end while (!f);
        chk(rd, exp, what);
    endtask
    // Notes whether the master reset shows within n cycles.
    task automatic watch(input int n);
        seen = 1'b0;
        repeat (n) begin
            @(negedge CLK);
            if (MASTER_SYSTEM_RESET === 1'b1) seen = 1'b1;
        end
        @(posedge CLK);
    endtask
    // Waits until the master reset has ended.
    task automatic settle();
        do @(negedge CLK); while (MASTER_SYSTEM_RESET !== 1'b0);
        @(posedge CLK);
    endtask
    // Drives one source for three cycles and checks that a reset follows.
    task automatic hit(input int i);
        case (i)
            0: WATCHDOG_TIMEOUT <= 1'b1;
            1: CONFIG_MISMATCH <= 1'b1;
            2: EXT_CLEAR_PIN_N <= 1'b0;
            default: BROWNOUT_DETECT <= 1'b1;
        endcase
        repeat (3) @(posedge CLK);
        WATCHDOG_TIMEOUT <= 1'b0;
        CONFIG_MISMATCH <= 1'b0;
        EXT_CLEAR_PIN_N <= 1'b1;
        BROWNOUT_DETECT <= 1'b0;
        watch(4);
        chk({31'h0, seen}, 32'h1, "source reset");
        settle();
    endtask
    // Two-key unlock sequence with full strobes.
    task automatic unlock();
        wr(`SRST_OFF_UNLOCK, `SRST_KEY1);
        wr(`SRST_OFF_UNLOCK, `SRST_KEY2);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        {RST, S_AXI_BREADY, S_AXI_RREADY, EXT_CLEAR_PIN_N} = 4'hF;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID, BROWNOUT_DETECT} = 4'h0;
        {WATCHDOG_TIMEOUT, CONFIG_MISMATCH, WAIT_EXECUTED, WAKE_EVENT} = 4'h0;
        {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WSTRB, S_AXI_WDATA} = 52'h0;
        repeat (4) @(posedge CLK);
        RST <= 1'b0;
        S_AXI_WSTRB <= 4'hF;
        settle();
        rchk(`SRST_OFF_CAUSE, 32'h1, "cause after reset");
        rchk(`SRST_OFF_TRIG, 32'h0, "trigger idle");
        rchk(`SRST_OFF_MODE, 32'h0, "mode after reset");
        rchk(8'h10, 32'h0, "unmapped read");
        chk({30'h0, rs}, 32'h2, "unmapped read resp");
        wr(8'h10, 32'h1);
        chk({30'h0, rs}, 32'h2, "unmapped write resp");
        wr(`SRST_OFF_CAUSE, 32'h0);
        rchk(`SRST_OFF_CAUSE, 32'h0, "cause cleared");
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            hit(i);
            rchk(`SRST_OFF_CAUSE, (i == 3) ? 32'h2 : 32'h0, "cause by source");
        end
        hit(3);
        wr(`SRST_OFF_CAUSE, 32'hF);
        rchk(`SRST_OFF_CAUSE, 32'h2, "brown-out held");
        wr(`SRST_OFF_CAUSE, 32'h0);
        rchk(`SRST_OFF_CAUSE, 32'h0, "brown-out cleared");
        hit(3);
        rchk(`SRST_OFF_CAUSE, 32'h2, "brown-out again");
        wr(`SRST_OFF_CAUSE, 32'h0);
        $display("test sources done");
        for (int m = 0; m < 2; m++) begin
            wr(`SRST_OFF_MODE, m ? 32'h10 : 32'h0);
            rchk(`SRST_OFF_MODE, m ? 32'h10 : 32'h0, "mode select");
            WAIT_EXECUTED <= 1'b1;
            @(posedge CLK);
            WAIT_EXECUTED <= 1'b0;
            @(negedge CLK);
            chk({LOW_POWER_SLEEP, LOW_POWER_IDLE}, m ? 32'h2 : 32'h1, "low power");
            @(posedge CLK);
            WAKE_EVENT <= 1'b1;
            @(posedge CLK);
            WAKE_EVENT <= 1'b0;
            rchk(`SRST_OFF_CAUSE, m ? 32'hC : 32'h4, "wake flags");
            wr(`SRST_OFF_CAUSE, 32'h0);
        end
        $display("test low power done");
        wr(`SRST_OFF_TRIG, 32'h1);
        rchk(`SRST_OFF_TRIG, 32'h0, "trigger locked");
        watch(12);
        chk({31'h0, seen}, 32'h0, "locked arm");
        wr(`SRST_OFF_UNLOCK, `SRST_KEY1);
        rchk(`SRST_OFF_UNLOCK, 32'h1, "key one seen");
        unlock();
        rchk(`SRST_OFF_UNLOCK, 32'h2, "lock open");
        wr(`SRST_OFF_TRIG, 32'h0);
        rchk(`SRST_OFF_TRIG, 32'h0, "trigger zero write");
        watch(12);
        chk({31'h0, seen}, 32'h0, "zero write arm");
        unlock();
        wr(`SRST_OFF_TRIG, 32'h1);
        rchk(`SRST_OFF_TRIG, 32'h0, "trigger armed read");
        watch(6);
        chk({31'h0, seen}, 32'h1, "armed read reset");
        settle();
        rchk(`SRST_OFF_TRIG, 32'h0, "trigger after reset");
        watch(12);
        chk({31'h0, seen}, 32'h0, "arm cleared");
        $display("test trigger done");
        test_done();
    end
endmodule
